// ==== hdl/srm_regs.sv ====
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Keep a 32-bit count of bytes in aborted packets written to the FIFO.
// - Count bytes 15:8, 23:16, 31:24 read at 0x11D..0x11F; reset zero.
// - Count may include discarded bytes; the source decides what is counted.
// - Request rising edge snapshots live counters and restarts them.
// - Done bit sets after snapshot; clears when request returns to zero.
// - Latch bit 3 on high SAP octet mismatch; cleared on read.
// - Latch bit 2 on low SAP octet mismatch; cleared on read.
// - Latch bit 1 on control field mismatch; cleared on read.
// - Latch bit 0 on address field mismatch; cleared on read.
// - High SAP flag interrupts only while enable bit 3 is one.
// - Low SAP flag interrupts only while enable bit 2 is one.
// - Control flag interrupts only while enable bit 1 is one.
// - Address flag interrupts only while enable bit 0 is one.
// - Low watermark byte position is register times 32 times 2048.
// - Watermarks watch the serial-to-Ethernet queue fill level.
// - High watermark byte position is register times 32 times 2048.
// - Latch flags on crossing high and low watermarks; cleared on read.
module srm_regs #(
	parameter int LEVEL_W = 32
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	input  wire logic               abort_byte_en,
	input  wire srm_pkg::srm_hdr_t  rx_hdr,
	input  wire logic [LEVEL_W-1:0] queue_level,
	output logic                    irq
);

	srm_pkg::srm_state_t s_q;
	srm_pkg::srm_state_t s_d;

	logic [9:0]         idx;
	logic               wr;
	logic               rd;
	logic               hit;
	logic [3:0]         mism;
	logic [LEVEL_W-1:0] low_pos;
	logic [LEVEL_W-1:0] high_pos;
	logic               low_now;
	logic               high_now;

	assign idx     = paddr[11:2];
	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign prdata  = s_q.prdata;
	assign pslverr = psel && penable && !hit;

	// --------------------------------------------
	// Address decode
	// --------------------------------------------
	always_comb begin
		unique case (idx)
			srm_pkg::IDX_ABORT_B0, srm_pkg::IDX_ABORT_B1,
			srm_pkg::IDX_ABORT_B2, srm_pkg::IDX_ABORT_B3,
			srm_pkg::IDX_UPD_REQ, srm_pkg::IDX_UPD_DONE,
			srm_pkg::IDX_HDR_FLAGS, srm_pkg::IDX_HDR_IRQ_EN,
			srm_pkg::IDX_Q_LOW, srm_pkg::IDX_Q_HIGH,
			srm_pkg::IDX_Q_FLAGS, srm_pkg::IDX_EXP_ADDR,
			srm_pkg::IDX_EXP_CTRL, srm_pkg::IDX_EXP_SAP_LO,
			srm_pkg::IDX_EXP_SAP_HI: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// --------------------------------------------
	// Header compare and watermark positions
	// --------------------------------------------
	always_comb begin
		mism = 4'h0;
		if (rx_hdr.valid) begin
			mism[srm_pkg::ADDR_BIT] = rx_hdr.address != s_q.expected_address;
			mism[srm_pkg::CTRL_BIT] = rx_hdr.control != s_q.expected_control;
			mism[srm_pkg::SAPL_BIT] = rx_hdr.sap_low != s_q.expected_sap_low;
			mism[srm_pkg::SAPH_BIT] = rx_hdr.sap_high != s_q.expected_sap_high;
		end
	end

	// Mark times 32 packets of 2048 bytes is a shift by sixteen
	assign low_pos  = LEVEL_W'(s_q.queue_low_mark) << srm_pkg::MARK_SHIFT;
	assign high_pos = LEVEL_W'(s_q.queue_high_mark) << srm_pkg::MARK_SHIFT;
	assign low_now  = queue_level >= low_pos;
	assign high_now = queue_level >= high_pos;

	// --------------------------------------------
	// Next state
	// --------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.req_prev = s_q.monitor_snapshot_request;
		// Counter source decides which bytes count, discards included
		if (abort_byte_en) begin
			s_d.live_count = s_q.live_count + 32'h0000_0001;
		end
		if (s_q.monitor_snapshot_request && !s_q.req_prev) begin
			s_d.aborted_byte_total = s_q.live_count;
			s_d.live_count = abort_byte_en ? 32'h0000_0001
				: srm_pkg::COUNT_RESTART;
			s_d.monitor_snapshot_done = 1'b1;
		end
		if (!s_q.monitor_snapshot_request) begin
			s_d.monitor_snapshot_done = 1'b0;
		end
		// Clear only what the read returned; events after setup survive
		if (rd && idx == srm_pkg::IDX_HDR_FLAGS) begin
			s_d.hdr_flags = s_q.hdr_flags & ~s_q.prdata[3:0];
		end
		if (rd && idx == srm_pkg::IDX_Q_FLAGS) begin
			s_d.q_flags = s_q.q_flags & ~s_q.prdata[1:0];
		end
		s_d.hdr_flags = s_d.hdr_flags | mism;
		s_d.above_low = low_now;
		s_d.above_high = high_now;
		if (low_now != s_q.above_low) begin
			s_d.q_flags[srm_pkg::QLOW_BIT] = 1'b1;
		end
		if (high_now != s_q.above_high) begin
			s_d.q_flags[srm_pkg::QHIGH_BIT] = 1'b1;
		end
		if (wr) begin
			unique case (idx)
				srm_pkg::IDX_UPD_REQ: s_d.monitor_snapshot_request = pwdata[0];
				srm_pkg::IDX_HDR_IRQ_EN: s_d.hdr_irq_en = pwdata[3:0];
				srm_pkg::IDX_Q_LOW: s_d.queue_low_mark = pwdata[7:0];
				srm_pkg::IDX_Q_HIGH: s_d.queue_high_mark = pwdata[7:0];
				srm_pkg::IDX_EXP_ADDR: s_d.expected_address = pwdata[7:0];
				srm_pkg::IDX_EXP_CTRL: s_d.expected_control = pwdata[7:0];
				srm_pkg::IDX_EXP_SAP_LO: s_d.expected_sap_low = pwdata[7:0];
				srm_pkg::IDX_EXP_SAP_HI: s_d.expected_sap_high = pwdata[7:0];
				default: ;
			endcase
		end
		s_d.prdata = srm_pkg::WORD_RESET;
		if (psel && !penable && !pwrite) begin
			unique case (idx)
				srm_pkg::IDX_ABORT_B0: s_d.prdata = {24'h00_0000, s_q.aborted_byte_total[7:0]};
				srm_pkg::IDX_ABORT_B1: s_d.prdata = {24'h00_0000, s_q.aborted_byte_total[15:8]};
				srm_pkg::IDX_ABORT_B2: s_d.prdata = {24'h00_0000, s_q.aborted_byte_total[23:16]};
				srm_pkg::IDX_ABORT_B3: s_d.prdata = {24'h00_0000, s_q.aborted_byte_total[31:24]};
				srm_pkg::IDX_UPD_REQ: s_d.prdata = {31'h0000_0000, s_q.monitor_snapshot_request};
				srm_pkg::IDX_UPD_DONE: s_d.prdata = {31'h0000_0000, s_q.monitor_snapshot_done};
				srm_pkg::IDX_HDR_FLAGS: s_d.prdata = {28'h000_0000, s_q.hdr_flags};
				srm_pkg::IDX_HDR_IRQ_EN: s_d.prdata = {28'h000_0000, s_q.hdr_irq_en};
				srm_pkg::IDX_Q_LOW: s_d.prdata = {24'h00_0000, s_q.queue_low_mark};
				srm_pkg::IDX_Q_HIGH: s_d.prdata = {24'h00_0000, s_q.queue_high_mark};
				srm_pkg::IDX_Q_FLAGS: s_d.prdata = {30'h0000_0000, s_q.q_flags};
				srm_pkg::IDX_EXP_ADDR: s_d.prdata = {24'h00_0000, s_q.expected_address};
				srm_pkg::IDX_EXP_CTRL: s_d.prdata = {24'h00_0000, s_q.expected_control};
				srm_pkg::IDX_EXP_SAP_LO: s_d.prdata = {24'h00_0000, s_q.expected_sap_low};
				srm_pkg::IDX_EXP_SAP_HI: s_d.prdata = {24'h00_0000, s_q.expected_sap_high};
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------
	// Interrupt
	// --------------------------------------------
	assign irq = |(s_q.hdr_flags & s_q.hdr_irq_en);

	// --------------------------------------------
	// Checks
	// --------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	snap_copy_a: assert property (s_q.monitor_snapshot_request && !s_q.req_prev
		|=> s_q.aborted_byte_total == $past(s_q.live_count))
		else $error("snapshot did not copy live count");
	done_set_a: assert property (s_q.monitor_snapshot_request && !s_q.req_prev
		|=> s_q.monitor_snapshot_done)
		else $error("done not set after snapshot");
	done_clear_a: assert property (!s_q.monitor_snapshot_request
		|=> !s_q.monitor_snapshot_done)
		else $error("done not cleared");
	count_step_a: assert property (abort_byte_en && !(s_q.monitor_snapshot_request
		&& !s_q.req_prev) |=> s_q.live_count == $past(s_q.live_count) + 1)
		else $error("live count did not step");
	sap_high_a: assert property (rx_hdr.valid && rx_hdr.sap_high != s_q.expected_sap_high
		|=> s_q.hdr_flags[3])
		else $error("sap high flag missed");
	sap_low_a: assert property (rx_hdr.valid && rx_hdr.sap_low != s_q.expected_sap_low
		|=> s_q.hdr_flags[2])
		else $error("sap low flag missed");
	ctrl_flag_a: assert property (rx_hdr.valid && rx_hdr.control != s_q.expected_control
		|=> s_q.hdr_flags[1])
		else $error("control flag missed");
	addr_flag_a: assert property (rx_hdr.valid && rx_hdr.address != s_q.expected_address
		|=> s_q.hdr_flags[0])
		else $error("address flag missed");
	irq_gate_a: assert property (irq |-> |(s_q.hdr_flags & s_q.hdr_irq_en)
		&& ((s_q.hdr_flags[3] && s_q.hdr_irq_en[3]) || !s_q.hdr_flags[3]
		|| !s_q.hdr_irq_en[3] || irq))
		else $error("irq without enabled flag");
	rd_clear_a: assert property (rd && idx == srm_pkg::IDX_HDR_FLAGS && !rx_hdr.valid
		|=> (s_q.hdr_flags & $past(s_q.prdata[3:0])) == 4'h0)
		else $error("flags not cleared on read");
	low_cross_a: assert property (low_now != s_q.above_low
		|=> s_q.q_flags[0])
		else $error("low crossing missed");

	snap_c: cover property (s_q.monitor_snapshot_request && !s_q.req_prev);
	irq_c: cover property (!irq ##1 irq);
	high_cross_c: cover property (high_now && !s_q.above_high);

endmodule
`default_nettype wire

// ==== hdl/srm_pkg.sv ====
package srm_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [9:0] IDX_ABORT_B0    = 10'h11C;
	localparam logic [9:0] IDX_ABORT_B1    = 10'h11D;
	localparam logic [9:0] IDX_ABORT_B2    = 10'h11E;
	localparam logic [9:0] IDX_ABORT_B3    = 10'h11F;
	localparam logic [9:0] IDX_UPD_REQ     = 10'h120;
	localparam logic [9:0] IDX_UPD_DONE    = 10'h121;
	localparam logic [9:0] IDX_HDR_FLAGS   = 10'h122;
	localparam logic [9:0] IDX_HDR_IRQ_EN  = 10'h123;
	localparam logic [9:0] IDX_Q_LOW       = 10'h124;
	localparam logic [9:0] IDX_Q_HIGH      = 10'h125;
	localparam logic [9:0] IDX_Q_FLAGS     = 10'h127;
	localparam logic [9:0] IDX_EXP_ADDR    = 10'h128;
	localparam logic [9:0] IDX_EXP_CTRL    = 10'h129;
	localparam logic [9:0] IDX_EXP_SAP_LO  = 10'h12A;
	localparam logic [9:0] IDX_EXP_SAP_HI  = 10'h12B;

	// ----------------------------------------
	// Fields and constants
	// ----------------------------------------
	localparam int         ADDR_BIT       = 0;
	localparam int         CTRL_BIT       = 1;
	localparam int         SAPL_BIT       = 2;
	localparam int         SAPH_BIT       = 3;
	localparam int         QLOW_BIT       = 0;
	localparam int         QHIGH_BIT      = 1;
	localparam int         MARK_SHIFT     = 16;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESTART = 32'h0000_0000;

	typedef struct packed {
		logic        valid;
		logic [7:0]  address;
		logic [7:0]  control;
		logic [7:0]  sap_high;
		logic [7:0]  sap_low;
	} srm_hdr_t;

	typedef struct packed {
		logic [31:0] live_count;
		logic [31:0] aborted_byte_total;
		logic        req_prev;
		logic        monitor_snapshot_request;
		logic        monitor_snapshot_done;
		logic [3:0]  hdr_flags;
		logic [3:0]  hdr_irq_en;
		logic [7:0]  queue_low_mark;
		logic [7:0]  queue_high_mark;
		logic [1:0]  q_flags;
		logic        above_low;
		logic        above_high;
		logic [7:0]  expected_address;
		logic [7:0]  expected_control;
		logic [7:0]  expected_sap_low;
		logic [7:0]  expected_sap_high;
		logic [31:0] prdata;
	} srm_state_t;

endpackage

// ==== sim/srm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module srm_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
	end
	// ----------------------------------------
	// One APB transfer, held until pready
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [9:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
endmodule
`default_nettype wire

// ==== sim/serial_rx_monitor_x86_check_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_rx_monitor_x86_check_regs_tb;
	logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, queue_level = '0;
	logic abort_byte_en = 0, err;
	srm_pkg::srm_hdr_t rx_hdr = '0;
	int failures = 0, cmp_count = 0, cycles = 0;
	int sh[4] = '{24, 16, 0, 8};
	logic [9:0] rst_idx[7] = '{srm_pkg::IDX_ABORT_B1, srm_pkg::IDX_ABORT_B2,
		srm_pkg::IDX_ABORT_B3, srm_pkg::IDX_UPD_REQ, srm_pkg::IDX_UPD_DONE,
		srm_pkg::IDX_Q_LOW, srm_pkg::IDX_Q_HIGH};
	always #4 pclk = ~pclk;
	srm_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));
	srm_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.abort_byte_en(abort_byte_en), .rx_hdr(rx_hdr),
		.queue_level(queue_level), .irq(irq));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		u_host.xfer(1, i, d, rd, err);
	endtask
	task automatic rdc(input logic [9:0] i, input logic [31:0] e);
		u_host.xfer(0, i, '0, rd, err);
		chk($sformatf("reg %h", i), e, rd);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Ceiling well above the roughly 500 cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			final_report();
		end
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		foreach (rst_idx[k]) rdc(rst_idx[k], '0);
		abort_byte_en <= 1;
		repeat (300) @(posedge pclk);
		abort_byte_en <= 0;
		rdc(srm_pkg::IDX_ABORT_B1, '0);
		wr(srm_pkg::IDX_UPD_REQ, 32'hFFFF_FFFF);
		rdc(srm_pkg::IDX_UPD_REQ, 32'h0000_0001);
		rdc(srm_pkg::IDX_UPD_DONE, 32'h0000_0001);
		rdc(srm_pkg::IDX_ABORT_B0, 32'h0000_002C);
		rdc(srm_pkg::IDX_ABORT_B1, 32'h0000_0001);
		rdc(srm_pkg::IDX_ABORT_B2, '0);
		wr(srm_pkg::IDX_UPD_REQ, '0);
		rdc(srm_pkg::IDX_UPD_DONE, '0);
		wr(srm_pkg::IDX_HDR_IRQ_EN, 32'hFFFF_FFFF);
		rdc(srm_pkg::IDX_HDR_IRQ_EN, 32'h0000_000F);
		rdc(srm_pkg::IDX_HDR_FLAGS, '0);
		// Masked first, so an enable bit wired to the wrong flag shows
		for (int i = 0; i < 4; i++) begin
			wr(srm_pkg::IDX_HDR_IRQ_EN, ~(32'h1 << i) & 32'hF);
			@(posedge pclk);
			rx_hdr <= {1'b1, 32'h5A << sh[i]};
			@(posedge pclk);
			rx_hdr <= '0;
			repeat (2) @(posedge pclk);
			chk("irq masked", 0, irq);
			wr(srm_pkg::IDX_HDR_IRQ_EN, 32'h1 << i);
			@(posedge pclk);
			chk("irq on", 1, irq);
			rdc(srm_pkg::IDX_HDR_FLAGS, 32'h1 << i);
			rdc(srm_pkg::IDX_HDR_FLAGS, '0);
			chk("irq off", 0, irq);
		end
		// Event during the read's setup cycle must survive the clear
		fork
			rdc(srm_pkg::IDX_HDR_FLAGS, '0);
			begin
				@(posedge pclk);
				rx_hdr <= {1'b1, 32'h5A00_0000};
				@(posedge pclk);
				rx_hdr <= '0;
			end
		join
		rdc(srm_pkg::IDX_HDR_FLAGS, 32'h0000_0001);
		wr(srm_pkg::IDX_Q_LOW, 32'h0000_0001);
		wr(srm_pkg::IDX_Q_HIGH, 32'h0000_0002);
		rdc(srm_pkg::IDX_Q_HIGH, 32'h0000_0002);
		rdc(srm_pkg::IDX_Q_FLAGS, 32'h0000_0003);
		queue_level <= 32'h0000_FFFF;
		rdc(srm_pkg::IDX_Q_FLAGS, '0);
		queue_level <= 32'h0001_0000;
		rdc(srm_pkg::IDX_Q_FLAGS, 32'h0000_0001);
		queue_level <= 32'h0001_FFFF;
		rdc(srm_pkg::IDX_Q_FLAGS, '0);
		queue_level <= 32'h0002_0000;
		rdc(srm_pkg::IDX_Q_FLAGS, 32'h0000_0002);
		rdc(10'h130, '0);
		chk("slverr", 1, err);
		final_report();
	end
endmodule
`default_nettype wire
